// file: hw/eight_bit_trigger_timer.sv
// eight-bit up counter with two compares, trigger gate and apb registers
`timescale 1ns/1ps
`default_nettype none
module eight_bit_trigger_timer (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer pins
  input wire logic trigger_input,
  input wire logic clear_input_pin,
  input wire logic externalClockPin,
  output logic timer_output_pin,
  // interrupt requests
  output logic overflowIrq,
  output logic matchIrqA,
  output logic matchIrqB
);
  import timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == OFF_CTRL0) || (a == OFF_CTRL1) || (a == OFF_STAT) ||
      (a == OFF_CNT) || (a == OFF_CMPA) || (a == OFF_CMPB);
  endfunction

  // prescaler tap for the internal codes
  function automatic logic [2:0] divTap(input logic [1:0] cks, input logic icks);
    divTap = 3'({cks, 1'b0} - 3'h1 + {2'h0, icks});
  endfunction

  // output action of one match, 00 when that match is absent
  function automatic logic [1:0] osAct(input logic hit, input logic [1:0] sel);
    osAct = hit ? sel : 2'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [3:0] outSel;
  logic match_flag_a;
  logic match_flag_b;
  logic ovf;
  logic [2:0] armed;
  logic [7:0] cnt;
  logic [7:0] cmpA;
  logic [7:0] cmpB;
  logic [PRE_W-1:0] pre;
  logic intLevel;
  logic halted;
  logic [2:0] trgSync;
  logic [2:0] clrSync;
  logic [2:0] extSync;
  bus_state_t busState;

  logic [7:0] next_ctrl0;
  logic [7:0] next_ctrl1;
  logic [3:0] next_outSel;
  logic next_match_flag_a;
  logic next_match_flag_b;
  logic next_ovf;
  logic [2:0] next_armed;
  logic [7:0] next_cnt;
  logic [7:0] next_cmpA;
  logic [7:0] next_cmpB;
  logic [PRE_W-1:0] next_pre;
  logic next_intLevel;
  logic next_halted;
  logic [2:0] next_trgSync;
  logic [2:0] next_clrSync;
  logic [2:0] next_extSync;
  bus_state_t next_busState;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_pin;
  logic next_ovfIrq;
  logic next_irqA;
  logic next_irqB;

  logic done;
  logic wrEn;
  logic wrStat;
  logic wrCnt;
  logic wrCmpA;
  logic wrCmpB;
  logic [7:0] wd;
  logic [7:0] rdVal;
  logic [2:0] cks;
  logic [1:0] cclr;
  logic [1:0] tveg;
  logic trigger_gate_enable;
  logic curLevel;
  logic tick;
  logic inc;
  logic matchA;
  logic matchB;
  logic clrRise;
  logic trgEdge;
  logic clearNow;
  logic [1:0] actA;
  logic [1:0] actB;
  logic [2:0] flagClr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cks = ctrl0[B_CKS +: 3];
    cclr = ctrl0[B_CCLR +: 2];
    tveg = ctrl1[B_TVEG +: 2];
    trigger_gate_enable = ctrl1[B_TRIGGER_GATE_ENABLE];
    wd = pwdata[7:0];
    done = psel && penable && (busState == BUS_ACK);
    wrEn = done && pwrite;
    wrStat = wrEn && (paddr == OFF_STAT);
    wrCnt = wrEn && (paddr == OFF_CNT);
    wrCmpA = wrEn && (paddr == OFF_CMPA);
    wrCmpB = wrEn && (paddr == OFF_CMPB);

    // pins pass two flops, the third holds the previous sample
    next_trgSync = {trgSync[1], trgSync[0], trigger_input};
    next_clrSync = {clrSync[1], clrSync[0], clear_input_pin};
    next_extSync = {extSync[1], extSync[0], externalClockPin};
    clrRise = clrSync[1] && !clrSync[2];
    case (tveg)
      EDGE_RISE: trgEdge = trgSync[1] && !trgSync[2];
      EDGE_FALL: trgEdge = !trgSync[1] && trgSync[2];
      EDGE_BOTH: trgEdge = trgSync[1] ^ trgSync[2];
      default: trgEdge = 1'b0;
    endcase

    // one level for every source, so a high-to-low switch also counts, except into CKS_EXT_RISE or CKS_EXT_BOTH
    next_pre = pre + 1'b1;
    case (cks)
      3'h1, 3'h2, 3'h3: curLevel = pre[divTap(cks[1:0], ctrl1[B_CLOCK_SELECT_LOW])];
      CKS_EXT_RISE, CKS_EXT_FALL, CKS_EXT_BOTH: curLevel = extSync[1];
      default: curLevel = 1'b0;
    endcase
    next_intLevel = curLevel;
    case (cks)
      CKS_EXT_RISE: tick = extSync[1] && !extSync[2];
      CKS_EXT_BOTH: tick = extSync[1] ^ extSync[2];
      default: tick = intLevel && !curLevel;
    endcase
    inc = tick && (!trigger_gate_enable || !halted);

    // match in the last equal state, i.e. as the counter leaves it
    matchA = inc && (cnt == cmpA) && !wrCmpA;
    matchB = inc && (cnt == cmpB) && !wrCmpB;
    clearNow = ((cclr == CLR_A) && matchA) || ((cclr == CLR_B) && matchB) ||
      ((cclr == CLR_PIN) && clrRise);

    // clear beats write beats increment
    if (clearNow)
      next_cnt = CNT_RST;
    else if (wrCnt)
      next_cnt = wd;
    else if (inc)
      next_cnt = cnt + 8'h01;
    else
      next_cnt = cnt;

    // halt after any clear, restart on the trigger edge
    if (!trigger_gate_enable)
      next_halted = 1'b0;
    else if (clearNow)
      next_halted = 1'b1;
    else if (trgEdge)
      next_halted = 1'b0;
    else
      next_halted = halted;

    // output pin priority toggle > high > low
    actA = osAct(matchA, outSel[B_OSA +: 2]);
    actB = osAct(matchB, outSel[B_OSB +: 2]);
    if (actA == OS_TOG || actB == OS_TOG)
      next_pin = !timer_output_pin;
    else if (actA == OS_HIGH || actB == OS_HIGH)
      next_pin = 1'b1;
    else if (actA == OS_LOW || actB == OS_LOW)
      next_pin = 1'b0;
    else
      next_pin = timer_output_pin;

    // clear needs a prior read as one; a set in the same cycle wins
    flagClr = {3{wrStat}} & armed & ~{wd[B_MATCH_FLAG_B], wd[B_MATCH_FLAG_A], wd[B_OVF]};
    next_match_flag_b = (match_flag_b && !flagClr[2]) || matchB;
    next_match_flag_a = (match_flag_a && !flagClr[1]) || matchA;
    next_ovf = (ovf && !flagClr[0]) ||
      (inc && !clearNow && !wrCnt && cnt == CNT_MAX);
    next_armed = wrStat ? 3'h0 : armed;
    if (done && !pwrite && paddr == OFF_STAT)
      next_armed = next_armed | {prdata[B_MATCH_FLAG_B], prdata[B_MATCH_FLAG_A], prdata[B_OVF]};

    // interrupt lines follow flags and enables one cycle later
    next_ovfIrq = ovf && ctrl0[B_OVERFLOW_IRQ_ENABLE];
    next_irqA = match_flag_a && ctrl0[B_MATCH_IRQ_ENABLE_A];
    next_irqB = match_flag_b && ctrl0[B_MATCH_IRQ_ENABLE_B];

    next_ctrl0 = (wrEn && paddr == OFF_CTRL0) ? wd : ctrl0;
    next_ctrl1 = (wrEn && paddr == OFF_CTRL1) ? (wd & CTRL1_WMASK) : ctrl1;
    next_outSel = wrStat ? wd[3:0] : outSel;
    next_cmpA = wrCmpA ? wd : cmpA;
    next_cmpB = wrCmpB ? wd : cmpB;

    case (paddr)
      OFF_CTRL0: rdVal = ctrl0;
      OFF_CTRL1: rdVal = ctrl1 | CTRL1_RSVD;
      OFF_STAT: rdVal = {match_flag_b, match_flag_a, ovf, 1'b0, outSel} | STAT_RSVD;
      OFF_CNT: rdVal = cnt;
      OFF_CMPA: rdVal = cmpA;
      OFF_CMPB: rdVal = cmpB;
      default: rdVal = 8'h00;
    endcase

    // one wait state so read data and error come from flops
    next_busState = BUS_WAIT;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && busState == BUS_WAIT)
    begin
      next_busState = BUS_ACK;
      next_prdata = {24'h000000, pwrite ? 8'h00 : rdVal};
      next_pslverr = !isMapped(paddr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ctrl0 <= CTRL0_RST;
      ctrl1 <= CTRL1_RST;
      outSel <= OS_RST;
      match_flag_a <= 1'b0;
      match_flag_b <= 1'b0;
      ovf <= 1'b0;
      armed <= 3'h0;
      cnt <= CNT_RST;
      cmpA <= CMP_RST;
      cmpB <= CMP_RST;
      pre <= '0;
      intLevel <= 1'b0;
      halted <= 1'b0;
      trgSync <= 3'h0;
      clrSync <= 3'h0;
      extSync <= 3'h0;
      busState <= BUS_WAIT;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      timer_output_pin <= 1'b0;
      overflowIrq <= 1'b0;
      matchIrqA <= 1'b0;
      matchIrqB <= 1'b0;
    end
    else
    begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      outSel <= next_outSel;
      match_flag_a <= next_match_flag_a;
      match_flag_b <= next_match_flag_b;
      ovf <= next_ovf;
      armed <= next_armed;
      cnt <= next_cnt;
      cmpA <= next_cmpA;
      cmpB <= next_cmpB;
      pre <= next_pre;
      intLevel <= next_intLevel;
      halted <= next_halted;
      trgSync <= next_trgSync;
      clrSync <= next_clrSync;
      extSync <= next_extSync;
      busState <= next_busState;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      timer_output_pin <= next_pin;
      overflowIrq <= next_ovfIrq;
      matchIrqA <= next_irqA;
      matchIrqB <= next_irqB;
    end
  end

  assign pready = (busState == BUS_ACK);
endmodule
`default_nettype wire

// file: hw/timer_pkg.sv
// constants for the eight-bit trigger timer
package timer_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CNT = 8'h0C;
  localparam logic [7:0] OFF_CMPA = 8'h10;
  localparam logic [7:0] OFF_CMPB = 8'h14;
  // first_timer_control fields
  localparam int B_MATCH_IRQ_ENABLE_B = 7;
  localparam int B_MATCH_IRQ_ENABLE_A = 6;
  localparam int B_OVERFLOW_IRQ_ENABLE = 5;
  localparam int B_CCLR = 3;
  localparam int B_CKS = 0;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  // second_timer_control fields
  localparam int B_TVEG = 3;
  localparam int B_TRIGGER_GATE_ENABLE = 2;
  localparam int B_CLOCK_SELECT_LOW = 0;
  localparam logic [7:0] CTRL1_RSVD = 8'hE2;
  localparam logic [7:0] CTRL1_WMASK = 8'h1D;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  // timer_flag_output_register fields
  localparam int B_MATCH_FLAG_B = 7;
  localparam int B_MATCH_FLAG_A = 6;
  localparam int B_OVF = 5;
  localparam int B_OSB = 2;
  localparam int B_OSA = 0;
  localparam logic [7:0] STAT_RSVD = 8'h10;
  localparam logic [3:0] OS_RST = 4'h0;
  // counter and compare reset values, counter maximum
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hFF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // clear select codes
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_PIN = 2'h3;
  // output select codes
  localparam logic [1:0] OS_LOW = 2'h1;
  localparam logic [1:0] OS_HIGH = 2'h2;
  localparam logic [1:0] OS_TOG = 2'h3;
  // trigger edge codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // clock select codes
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
  // prescaler width: bit k toggles with period 2^(k+1) system clocks
  localparam int PRE_W = 7;
  // apb answer
  typedef enum logic [0:0] {BUS_WAIT = 1'b0, BUS_ACK = 1'b1} bus_state_t;
endpackage

// file: tb/pin_driver.sv
// board logic driving the timer's trigger, clear and clock pins
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
  // system
  input wire logic clk_sys,
  // pins
  output logic trigger_input,
  output logic clear_input_pin,
  output logic externalClockPin
);
  initial
  begin
    trigger_input = 1'b0;
    clear_input_pin = 1'b0;
    externalClockPin = 1'b0;
  end
  task automatic pulse(input logic clr);
    @(posedge clk_sys);
    if (clr)
      clear_input_pin <= 1'b1;
    else
      trigger_input <= 1'b1;
    // three clocks so the two-flop synchroniser cannot miss it
    repeat (3) @(posedge clk_sys);
    clear_input_pin <= 1'b0;
    trigger_input <= 1'b0;
  endtask
  // clock runs only inside a burst and rests low
  task automatic burst(input int cnt);
    repeat (cnt)
    begin
      repeat (4) @(posedge clk_sys);
      externalClockPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      externalClockPin <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the eight-bit trigger timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import timer_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic x;} row_t;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, timer_output_pin, x;
  logic trigger_input, clear_input_pin, externalClockPin, overflowIrq, matchIrqA, matchIrqB;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, q;
  int mismatches, checks, n, k;
  row_t rows [8] = '{
    '{1'b0, OFF_CTRL0, 8'h00, CTRL0_RST, 1'b0}, '{1'b0, OFF_CTRL1, 8'h00, 8'hE2, 1'b0},
    '{1'b0, OFF_STAT, 8'h00, 8'h10, 1'b0}, '{1'b0, OFF_CMPA, 8'h00, CMP_RST, 1'b0},
    '{1'b1, OFF_CTRL1, 8'hFF, 8'hFF, 1'b0}, '{1'b1, OFF_CTRL1, 8'h00, 8'hE2, 1'b0},
    '{1'b1, OFF_CMPB, 8'h5A, 8'h5A, 1'b0}, '{1'b1, 8'h18, 8'h33, 8'h00, 1'b1}};
  eight_bit_trigger_timer dut (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_input(trigger_input), .clear_input_pin(clear_input_pin),
    .externalClockPin(externalClockPin), .timer_output_pin(timer_output_pin),
    .overflowIrq(overflowIrq), .matchIrqA(matchIrqA), .matchIrqB(matchIrqB));
  pin_driver pins (.clk_sys(clk_sys), .trigger_input(trigger_input),
    .clear_input_pin(clear_input_pin), .externalClockPin(externalClockPin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // look at pready mid-cycle, where it has settled, then end at the next rising edge
    do
      @(negedge clk_sys);
    while (pready !== 1'b1);
    r = prdata;
    x = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(r, e);
  endtask
  task automatic wait_pin;
    logic p;
    p = timer_output_pin;
    for (n = 0; n < 300 && timer_output_pin === p; n++)
      @(posedge clk_sys);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    chk(32'(timer_output_pin), 32'h0);
    foreach (rows[i])
    begin
      if (rows[i].w)
        apb(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, 32'(rows[i].e));
      chk(32'(x), 32'(rows[i].x));
    end
    // clear on match a at 5, divide by 4: toggle every six counts
    apb(1'b1, OFF_CMPA, 8'h05);
    apb(1'b1, OFF_STAT, {6'h00, OS_TOG});
    apb(1'b1, OFF_CTRL0, 8'h49);
    wait_pin();
    wait_pin();
    chk(32'(n), 32'd24);
    chk(32'(matchIrqA), 32'h1);
    apb(1'b1, OFF_CTRL0, 8'h48);
    apb(1'b0, OFF_CNT, 8'h00);
    q = r;
    repeat (20) @(posedge clk_sys);
    rd(OFF_CNT, q);
    rd(OFF_STAT, 32'h53);
    apb(1'b1, OFF_STAT, 8'h03);
    rd(OFF_STAT, 32'h13);
    apb(1'b1, OFF_CNT, 8'hFD);
    rd(OFF_CNT, 32'hFD);
    apb(1'b1, OFF_CTRL0, 8'h21);
    for (n = 0; n < 100 && overflowIrq !== 1'b1; n++)
      @(posedge clk_sys);
    chk(32'(overflowIrq), 32'h1);
    apb(1'b1, OFF_CTRL0, 8'h00);
    apb(1'b1, OFF_STAT, 8'h03);
    rd(OFF_STAT, 32'h33);
    for (k = 0; k < 3; k++)
    begin
      apb(1'b1, OFF_CTRL0, 8'(CKS_EXT_RISE + k));
      apb(1'b1, OFF_CNT, 8'h00);
      pins.burst(5);
      repeat (8) @(posedge clk_sys);
      rd(OFF_CNT, (k == 2) ? 32'h0A : 32'h05);
    end
    apb(1'b1, OFF_CTRL1, 8'h0C);
    apb(1'b1, OFF_CTRL0, 8'h19);
    pins.pulse(1'b1);
    repeat (8) @(posedge clk_sys);
    rd(OFF_CNT, 32'h00);
    repeat (30) @(posedge clk_sys);
    rd(OFF_CNT, 32'h00);
    pins.pulse(1'b0);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, OFF_CNT, 8'h00);
    chk(32'(r[7:0] != 8'h00), 32'h1);
    apb(1'b1, OFF_CTRL1, 8'h08);
    pins.pulse(1'b1);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, OFF_CNT, 8'h00);
    chk(32'(r[7:0] != 8'h00), 32'h1);
    resetn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFF_CTRL1, 32'hE2);
    chk(32'(timer_output_pin), 32'h0);
    // both matches at once: a drives low, b toggles; toggle must win
    apb(1'b1, OFF_CMPA, 8'h03);
    apb(1'b1, OFF_CMPB, 8'h03);
    apb(1'b1, OFF_STAT, 8'h0D);
    apb(1'b1, OFF_CTRL0, 8'hC9);
    wait_pin();
    chk(32'(timer_output_pin), 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(32'(matchIrqB), 32'h1);
    complete_run();
  end
endmodule
bind eight_bit_trigger_timer timer_props props (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .timer_output_pin(timer_output_pin), .overflowIrq(overflowIrq), .matchIrqA(matchIrqA),
  .matchIrqB(matchIrqB));
`default_nettype wire

// file: tb/timer_props.sv
// assertion checker on the timer's bus and pin ports
`timescale 1ns/1ps
`default_nettype none
module timer_props (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // pins
  input wire logic timer_output_pin,
  input wire logic overflowIrq,
  input wire logic matchIrqA,
  input wire logic matchIrqB
);
  import timer_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [7:0] ctl0;
  logic [3:0] osel;
  wire logic done = psel && penable && pready;
  wire logic wrAny = done && pwrite && (paddr == OFF_STAT || paddr == OFF_CTRL0);
  // shadows change at the same edge as the registers they mirror
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      {ctl0, osel} <= 12'h000;
    else if (done && pwrite && paddr == OFF_CTRL0)
      ctl0 <= pwdata[7:0];
    else if (done && pwrite && paddr == OFF_STAT)
      osel <= pwdata[3:0];
  end
  property p_rsvd;
    done && !pwrite && paddr == OFF_CTRL1 |-> &{prdata[7:5], prdata[1]};
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits low");
  property p_pin_rst; $rose(resetn) |-> !timer_output_pin; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin high after reset");
  property p_ovf_en; !ctl0[B_OVERFLOW_IRQ_ENABLE] |=> !overflowIrq; endproperty
  a_ovf_en: assert property (p_ovf_en) else $error("overflow irq masked");
  property p_irq_a; !ctl0[B_MATCH_IRQ_ENABLE_A] |=> !matchIrqA; endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a masked");
  property p_irq_b; !ctl0[B_MATCH_IRQ_ENABLE_B] |=> !matchIrqB; endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b masked");
  property p_flag_hold;
    matchIrqA && ctl0[B_MATCH_IRQ_ENABLE_A] && !wrAny && !$past(wrAny) |=> matchIrqA;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag a lost");
  property p_os_hold; osel == 4'h0 |=> $stable(timer_output_pin); endproperty
  a_os_hold: assert property (p_os_hold) else $error("pin moved");
  property p_tog_flag;
    ctl0[B_MATCH_IRQ_ENABLE_A] && osel == 4'h3 && $changed(timer_output_pin) |=> matchIrqA;
  endproperty
  a_tog_flag: assert property (p_tog_flag) else $error("toggle without match");
  c_tog: cover property ($changed(timer_output_pin));
  c_ovf: cover property ($rose(overflowIrq));
  c_match: cover property ($rose(matchIrqA));
endmodule
`default_nettype wire
